// ==== hdl/opaa_phase_tool.sv ====
// Arm and trigger sequencer for output phase adjust and align
`default_nettype none
`include "opaa_defines.svh"
module opaa_phase_tool
  import opaa_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_fast_tick,
  input wire logic i_mode,
  input wire logic [3:0] i_readiness_source_select,
  input wire logic [3:0] i_fire_source_select,
  input wire logic i_fire_sense_invert,
  input wire logic i_arm_request,
  input wire logic i_fire_request_bit,
  input wire logic i_abort,
  input wire logic i_done_clear,
  input wire logic i_analog_loop_lock,
  input wire logic i_digital_loop_lock,
  input wire logic i_digital_loop_ref_clk,
  input wire logic [3:0] i_gpio,
  input wire opaa_pkg::opaa_out_cfg_t [2:0] i_out_cfg,
  output logic [2:0] o_out_clk,
  output opaa_pkg::opaa_status_t o_status
);
  opaa_state_t state;
  logic arm_prev;
  logic fire_prev;
  logic alock_prev;
  logic dlock_prev;
  logic dclk_prev;
  logic [3:0] gpio_prev;
  logic fire_sig_prev;
  logic arm_evt;
  logic fire_sig;
  logic fire_evt;
  logic [2:0] apply;
  logic [2:0] div_clk;
  logic [2:0] div_done;
  logic apply_pulse;
  logic [2:0] waiting;
  logic relock_hold;

  // Maps a source code to a GPIO index match
  function automatic logic gpio_pick(input logic [3:0] code,
                                     input logic [3:0] base,
                                     input logic [3:0] g);
    logic [3:0] idx;
    idx = code - base;
    gpio_pick = (code >= base) && (idx < 4'h4) && g[idx[1:0]];
  endfunction

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      // Tracking the live levels in reset avoids a false edge at release
      arm_prev <= i_arm_request;
      fire_prev <= i_fire_request_bit;
      alock_prev <= i_analog_loop_lock;
      dlock_prev <= i_digital_loop_lock;
      dclk_prev <= i_digital_loop_ref_clk;
      gpio_prev <= i_gpio;
      fire_sig_prev <= fire_sig;
    end else begin
      arm_prev <= i_arm_request;
      fire_prev <= i_fire_request_bit;
      alock_prev <= i_analog_loop_lock;
      dlock_prev <= i_digital_loop_lock;
      dclk_prev <= i_digital_loop_ref_clk;
      gpio_prev <= i_gpio;
      fire_sig_prev <= fire_sig;
    end
  end

  // GPIO arm reacts to any transition on the chosen pin
  always_comb begin
    unique case (i_readiness_source_select)
      `OPAA_ARM_SRC_BIT: arm_evt = i_arm_request & ~arm_prev;
      `OPAA_ARM_SRC_ALOCK: arm_evt = i_analog_loop_lock & ~alock_prev;
      `OPAA_ARM_SRC_DLOCK: arm_evt = i_digital_loop_lock & ~dlock_prev;
      default: arm_evt = gpio_pick(i_readiness_source_select,
                  `OPAA_ARM_SRC_GPIO0, i_gpio ^ gpio_prev);
    endcase
  end

  // Fire source is a level here; its rising edge is the event
  always_comb begin
    unique case (i_fire_source_select)
      `OPAA_TRG_SRC_BIT: fire_sig = i_fire_request_bit;
      `OPAA_TRG_SRC_ALOCK: fire_sig = i_analog_loop_lock;
      `OPAA_TRG_SRC_DLOCK: fire_sig = i_digital_loop_lock;
      `OPAA_TRG_SRC_DCLK: fire_sig = i_digital_loop_ref_clk;
      default: fire_sig = gpio_pick(i_fire_source_select,
                  `OPAA_TRG_SRC_GPIO0, i_gpio);
    endcase
    fire_sig = fire_sig ^ i_fire_sense_invert;
  end
  // Fire source must return to its inactive level (zero unless inverted) before it fires again
  assign fire_evt = fire_sig & ~fire_sig_prev;

  // Alignment on analog lock trigger stays armed so each relock realigns
  assign relock_hold = (i_mode == `OPAA_MODE_ALIGN) &&
                       (i_fire_source_select == `OPAA_TRG_SRC_ALOCK);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state <= OPAA_IDLE;
      apply_pulse <= 1'b0;
    end else begin
      apply_pulse <= 1'b0;
      if (i_abort) begin
        state <= OPAA_IDLE;
      end else begin
        unique case (state)
          OPAA_IDLE: if (arm_evt) state <= OPAA_ARMED;
          OPAA_ARMED: begin
            if (fire_evt) begin
              state <= OPAA_SHIFT;
              apply_pulse <= 1'b1;
            end
          end
          OPAA_SHIFT: begin
            if (!apply_pulse && waiting == 3'h0) begin
              state <= relock_hold ? OPAA_ARMED : OPAA_IDLE;
            end
          end
        endcase
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `OPAA_NUM_OUT; g = g + 1) begin : gen_out
      // Alignment always participates if permitted, even with step zero
      assign apply[g] = apply_pulse && i_out_cfg[g].permit &&
                        (i_out_cfg[g].step != 8'h00 ||
                         i_mode == `OPAA_MODE_ALIGN);
      opaa_mid_divider u_div (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_fast_tick(i_fast_tick),
        .i_cfg(i_out_cfg[g]),
        .i_apply(apply[g] && i_out_cfg[g].step != 8'h00),
        .i_align(apply[g] && i_mode == `OPAA_MODE_ALIGN),
        .o_clk(div_clk[g]),
        .o_done(div_done[g])
      );
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || i_abort) begin
          waiting[g] <= 1'b0;
        end else if (apply[g] && i_out_cfg[g].step != 8'h00 &&
                     i_out_cfg[g].mid_div != 7'h00) begin
          waiting[g] <= 1'b1;
        end else if (div_done[g]) begin
          waiting[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_out_clk <= 3'h0;
    end else begin
      o_out_clk <= div_clk;
    end
  end

  // Sticky done: a completion in the clear cycle still sets it
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_status <= '0;
    end else begin
      o_status.armed <= (state == OPAA_ARMED);
      o_status.busy <= (state == OPAA_SHIFT);
      if (state == OPAA_SHIFT && !apply_pulse && waiting == 3'h0) begin
        o_status.done_latched <= 1'b1;
      end else if (i_done_clear) begin
        o_status.done_latched <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/opaa_defines.svh ====
// Constants for the output phase adjust and align block
`ifndef OPAA_DEFINES_SVH
`define OPAA_DEFINES_SVH
`define OPAA_NUM_OUT 3
`define OPAA_MODE_ALIGN 1'h0
`define OPAA_MODE_ADJUST 1'h1
`define OPAA_ARM_SRC_BIT 4'h1
`define OPAA_ARM_SRC_ALOCK 4'h2
`define OPAA_ARM_SRC_DLOCK 4'h3
`define OPAA_ARM_SRC_GPIO0 4'h4
`define OPAA_TRG_SRC_BIT 4'h0
`define OPAA_TRG_SRC_ALOCK 4'h1
`define OPAA_TRG_SRC_DLOCK 4'h2
`define OPAA_TRG_SRC_DCLK 4'h3
`define OPAA_TRG_SRC_GPIO0 4'h4
`define OPAA_NUM_GPIO 4
`define OPAA_MAX_NEG_ODD_OFS 8'h01
`define OPAA_MAX_NEG_EVEN_OFS 8'h02
`define OPAA_MAX_POS_ODD_BASE 8'h7f
`define OPAA_MAX_POS_EVEN_BASE 8'h80
`endif

// ==== hdl/opaa_pkg.sv ====
// Types for the output phase adjust and align block
`default_nettype none
package opaa_pkg;
  typedef struct packed {
    logic permit;
    logic invert;
    logic [6:0] mid_div;
    logic [7:0] step;
  } opaa_out_cfg_t;
  typedef struct packed {
    logic armed;
    logic busy;
    logic done_latched;
  } opaa_status_t;
  typedef enum logic [2:0] {
    OPAA_IDLE = 3'b001,
    OPAA_ARMED = 3'b010,
    OPAA_SHIFT = 3'b100
  } opaa_state_t;
endpackage
`default_nettype wire

// ==== hdl/opaa_mid_divider.sv ====
// One output's medium-rate divider with phase step and reset
`default_nettype none
`include "opaa_defines.svh"
module opaa_mid_divider
  import opaa_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_fast_tick,
  input wire opaa_pkg::opaa_out_cfg_t i_cfg,
  input wire logic i_apply,
  input wire logic i_align,
  output logic o_clk,
  output logic o_done
);
  // Counts fast ticks left in the current half; a full output period
  // is mid_div ticks high and mid_div ticks low
  logic [7:0] half_cnt;
  logic [7:0] extra;
  logic pending;
  logic stretch;
  logic in_high;
  logic start_high;
  logic [7:0] high_len;
  assign in_high = o_clk ^ i_cfg.invert;
  // The low half runs out and the next high half begins
  assign start_high = i_fast_tick && !i_align && i_cfg.mid_div != 7'h00 &&
                      half_cnt == 8'h00 && !in_high;
  // Clamping keeps this sum within eight bits and above zero
  assign high_len = {1'b0, i_cfg.mid_div} + extra;

  // Clamp a signed step to the allowed range for this divider value
  function automatic logic [7:0] clamp_step(input logic [7:0] st,
                                            input logic [6:0] dv);
    logic [7:0] dv8;
    logic [7:0] neg_max;
    logic [7:0] pos_max;
    logic [7:0] mag;
    dv8 = {1'b0, dv};
    neg_max = dv[0] ? (dv8 - `OPAA_MAX_NEG_ODD_OFS) :
              (dv8 - `OPAA_MAX_NEG_EVEN_OFS);
    pos_max = dv[0] ? (`OPAA_MAX_POS_ODD_BASE - dv8) :
              (`OPAA_MAX_POS_EVEN_BASE - dv8);
    // Limits above are in fast ticks, the same unit as the step itself
    mag = st[7] ? (8'h00 - st) : st;
    if (st[7]) begin
      clamp_step = (mag > neg_max) ? (8'h00 - neg_max) : st;
    end else begin
      clamp_step = (mag > pos_max) ? pos_max : st;
    end
  endfunction

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pending <= 1'b0;
      extra <= 8'h00;
    end else if (i_apply && i_cfg.mid_div != 7'h00) begin
      pending <= 1'b1;
      extra <= clamp_step(i_cfg.step, i_cfg.mid_div);
    end else if (pending && start_high) begin
      pending <= 1'b0;
    end
  end

  // One high half is stretched or shrunk; the low half stays nominal
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      half_cnt <= 8'h00;
      o_clk <= 1'b0;
      o_done <= 1'b0;
      stretch <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_align) begin
        half_cnt <= 8'h00;
        o_clk <= i_cfg.invert;
        stretch <= 1'b0;
      end else if (i_fast_tick && i_cfg.mid_div != 7'h00) begin
        if (half_cnt != 8'h00) begin
          half_cnt <= half_cnt - 8'h01;
        end else if (in_high) begin
          // Done is reported once the altered high half has ended
          o_clk <= i_cfg.invert;
          half_cnt <= {1'b0, i_cfg.mid_div} - 8'h01;
          o_done <= stretch;
          stretch <= 1'b0;
        end else begin
          o_clk <= ~i_cfg.invert;
          if (pending) begin
            half_cnt <= high_len - 8'h01;
          end else begin
            half_cnt <= {1'b0, i_cfg.mid_div} - 8'h01;
          end
          stretch <= pending;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/opaa_phase_tool_monitor.sv ====
// Assertion checker for the phase tool sequencer
`default_nettype none
module opaa_phase_tool_monitor
  import opaa_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_readiness_source_select,
  input wire logic i_arm_request,
  input wire logic i_abort,
  input wire logic i_done_clear,
  input wire logic [2:0] o_out_clk,
  input wire opaa_pkg::opaa_status_t o_status
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  a_reset_quiet: assert property (disable iff (1'b0)
    i_sys_rst |=> o_status == 3'h0 && o_out_clk == 3'h0)
    else $error("outputs not quiet in reset");
  a_abort_idle: assert property (i_abort ##1 i_abort
    |=> !o_status.armed && !o_status.busy) else $error("abort ignored");
  a_state_excl: assert property (!(o_status.armed && o_status.busy))
    else $error("armed and busy together");
  a_busy_armed: assert property ($rose(o_status.busy)
    |-> $past(o_status.armed)) else $error("shift without arm");
  a_done_follow: assert property ($fell(o_status.busy)
    && !$past(i_abort) && !$past(i_abort, 2) |-> o_status.done_latched)
    else $error("shift ended without done");
  a_done_sticky: assert property (o_status.done_latched
    && !i_done_clear |=> o_status.done_latched) else $error("done lost");
  a_done_clear: assert property (i_done_clear && !o_status.busy
    && !o_status.armed && !$past(o_status.busy) && !$past(o_status.armed)
    |=> !o_status.done_latched) else $error("done not cleared");
  a_arm_taken: assert property (disable iff (i_sys_rst || i_abort)
    $rose(i_arm_request) && i_readiness_source_select == 4'h1
    && !o_status.armed && !o_status.busy |-> ##[1:2] o_status.armed)
    else $error("arm bit not taken");
endmodule
bind opaa_phase_tool opaa_phase_tool_monitor i_mon (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_readiness_source_select(i_readiness_source_select),
  .i_arm_request(i_arm_request), .i_abort(i_abort),
  .i_done_clear(i_done_clear), .o_out_clk(o_out_clk), .o_status(o_status));
`default_nettype wire

// ==== tb/opaa_clk_receiver.sv ====
// Downstream clock receiver that measures output high time
`default_nettype none
module opaa_clk_receiver (
  input wire logic i_core_clk,
  input wire logic i_clear,
  input wire logic i_clk_in,
  output logic [15:0] o_min_len,
  output logic [15:0] o_max_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] run = 16'h0;
  logic prev = 1'b0;
  logic seen = 1'b0;
  // Shortest and longest high pulse since the last clear; a pulse cut
  // by the clear is skipped, since only whole pulses are measured
  always @(posedge i_core_clk) begin
    prev <= i_clk_in;
    if (i_clear) begin
      seen <= 1'b0;
      o_min_len <= 16'hffff;
      o_max_len <= 16'h0;
    end else if (i_clk_in && !prev) begin
      seen <= 1'b1;
      run <= 16'h1;
    end else if (i_clk_in) begin
      run <= run + 16'h1;
    end else if (prev && seen) begin
      if (run < o_min_len) o_min_len <= run;
      if (run > o_max_len) o_max_len <= run;
    end
  end
endmodule
`default_nettype wire

// ==== tb/opaa_phase_tool_test.sv ====
// Self-checking bench for the phase tool sequencer
`default_nettype none
module opaa_phase_tool_test;
  timeunit 1ns;
  timeprecision 1ns;
  import opaa_pkg::*;
  logic clk = 1'b0, rst = 1'b1, tick = 1'b0, mode = 1'b1, inv = 1'b0;
  logic arm = 1'b0, fire = 1'b0, abort = 1'b0, dclr = 1'b0;
  logic alock = 1'b0, dlock = 1'b0, dclk = 1'b0;
  logic [3:0] asel = 4'h1, fsel = 4'h0, gpio = 4'h0;
  opaa_out_cfg_t [2:0] cfg;
  logic [2:0] oclk;
  opaa_status_t st;
  logic rxclr = 1'b0;
  logic [15:0] lo [3];
  logic [15:0] hi [3];
  int err_total = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  // Step unit is two core cycles
  always @(negedge clk) tick <= ~tick;
  opaa_phase_tool i_dut (.i_core_clk(clk), .i_sys_rst(rst),
    .i_fast_tick(tick), .i_mode(mode), .i_readiness_source_select(asel),
    .i_fire_source_select(fsel), .i_fire_sense_invert(inv),
    .i_arm_request(arm), .i_fire_request_bit(fire), .i_abort(abort),
    .i_done_clear(dclr), .i_analog_loop_lock(alock),
    .i_digital_loop_lock(dlock), .i_digital_loop_ref_clk(dclk),
    .i_gpio(gpio), .i_out_cfg(cfg), .o_out_clk(oclk), .o_status(st));
  for (genvar k = 0; k < 3; k++) begin : g_rx
    opaa_clk_receiver i_rx (.i_core_clk(clk), .i_clear(rxclr),
      .i_clk_in(oclk[k]), .o_min_len(lo[k]), .o_max_len(hi[k]));
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    while (st[b] !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check(16'(st[b]), 16'h1);
  endtask
  task automatic set_line(input logic [3:0] c, input logic a, input logic v);
    @(negedge clk);
    case (c)
      4'h0: fire = v;
      4'h1: if (a) arm = v; else alock = v;
      4'h2: if (a) alock = v; else dlock = v;
      4'h3: if (a) dlock = v; else dclk = v;
      default: gpio[0] = v;
    endcase
  endtask
  // Abort after every source change so no stale edge arms the tool
  task automatic prep(input logic [3:0] a, input logic [3:0] f,
                      input logic iv, input logic m);
    @(negedge clk);
    abort = 1'b1;
    dclr = 1'b1;
    rxclr = 1'b1;
    {arm, fire, alock, dlock, dclk, gpio} = 9'h0;
    {asel, fsel, inv, mode} = {a, f, iv, m};
    repeat (3) @(negedge clk);
    abort = 1'b0;
    dclr = 1'b0;
    rxclr = 1'b0;
    @(negedge clk);
    check(16'(st), 16'h0);
  endtask
  task automatic fire_pair(input logic [3:0] a, input logic [3:0] f,
                           input logic iv, input logic m);
    prep(a, f, iv, m);
    set_line(a, 1'b1, 1'b1);
    wait_bit(2);
    set_line(f, 1'b0, ~iv);
    wait_bit(0);
  endtask
  initial begin
    cfg[0] = '{1'b1, 1'b0, 7'h04, 8'h02};
    // Small negative step keeps the shortened high pulse usable
    cfg[1] = '{1'b1, 1'b0, 7'h06, 8'hfe};
    cfg[2] = '{1'b0, 1'b0, 7'h05, 8'h03};
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (40) @(negedge clk);
    for (int r = 0; r < 2; r++) begin
      // Second round asks for more negative shift than the divider allows
      cfg[1].step = r ? 8'hf0 : 8'hfe;
      fire_pair(4'h1, 4'h0, 1'b0, 1'b1);
      repeat (40) @(negedge clk);
      check(hi[0], 16'h000c);
      check(lo[1], r ? 16'h0004 : 16'h0008);
      check(lo[2], 16'h000a);
      check(hi[2], 16'h000a);
    end
    prep(4'h1, 4'h0, 1'b0, 1'b1);
    set_line(4'h0, 1'b0, 1'b1);
    repeat (10) @(negedge clk);
    check(16'(st), 16'h0);
    prep(4'h1, 4'h0, 1'b0, 1'b1);
    set_line(4'h1, 1'b1, 1'b1);
    wait_bit(2);
    abort = 1'b1;
    @(negedge clk);
    abort = 1'b0;
    set_line(4'h0, 1'b0, 1'b1);
    repeat (10) @(negedge clk);
    check(16'(st), 16'h0);
    for (int i = 1; i < 5; i++) begin
      fire_pair(4'(i), 4'(i), i == 4, 1'b1);
    end
    fire_pair(4'h1, 4'h1, 1'b0, 1'b0);
    wait_bit(2);
    set_line(4'h1, 1'b0, 1'b0);
    dclr = 1'b1;
    @(negedge clk);
    dclr = 1'b0;
    set_line(4'h1, 1'b0, 1'b1);
    wait_bit(0);
    tally_and_finish();
  end
  initial begin
    #3000000;
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
